/* File: hdl/eprom_prog_pkg.sv */
// Constants for the external memory programmer controller
package eprom_prog_pkg;
  localparam int ADDR_W = 15;                  // Address width (32K bytes)
  localparam int DATA_W = 8;                   // Byte width
  localparam int CLK_MHZ = 40;                 // Clock rate in MHz
  localparam int PULSE_NOM_US = 100;           // Nominal program pulse, us
  localparam int PULSE_CYC = PULSE_NOM_US * CLK_MHZ; // Pulse length in cycles
  localparam int SETUP_US = 2;                 // Address, data, strobe and supply setup, us
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;     // Setup in cycles
  localparam int OE_VALID_NS = 150;            // Data valid after output gate falls, ns
  localparam int CLK_NS = 25;                  // Clock period, ns
  localparam int OE_VALID_CYC = (OE_VALID_NS + CLK_NS - 1) / CLK_NS + 2; // Plus sync
  localparam int FLOAT_NS = 130;               // Output gate high to float, ns
  localparam int FLOAT_CYC = (FLOAT_NS + CLK_NS - 1) / CLK_NS; // Float wait in cycles
  localparam int MAX_TRIES = 25;               // Pulse attempts per byte
  localparam int CNT_W = 16;                   // Timer width
  localparam int TRY_W = 5;                    // Attempt counter width
endpackage : eprom_prog_pkg

/* File: hdl/eprom_programmer.sv */
// Programmer that drives a UV-erasable memory through its pins
//
// Contract
// - Program needs raised supply; byte on data
// - Select low pulse, gate high, writes byte
// - Verify: select high, gate low, read
// - Verify after every program pulse
// - Pulse then read back until match
// - Abort run after 25 failed pulses
// - End: normal supplies, compare whole image
// - Program pulse lasts 95 to 105 us
// - Main supply up first, down last
// - Decoder drives select; gates share read
`timescale 1ns/1ps
`default_nettype none
module eprom_programmer
  import eprom_prog_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC      // Program pulse length, shortenable
) (
  input wire logic i_clk,                     // 40 MHz clock
  input wire logic i_resetn,                  // Async reset, active low
  input wire logic i_start,                   // Pulse: start a programming run
  input wire logic i_read_id,                 // Pulse: read maker and part codes
  input wire logic [ADDR_W-1:0] i_last_addr,  // Last address of the image
  output logic o_img_req,                     // Level: image byte wanted
  output logic [ADDR_W-1:0] o_img_addr,       // Address of image byte wanted
  input wire logic [DATA_W-1:0] i_img_data,   // Image byte, valid with o_img_req
  output logic o_busy,                        // Level: run or id read in progress
  output logic o_done,                        // Pulse: run or id read finished
  output logic o_fail,                        // Level: last run failed
  output logic [ADDR_W-1:0] o_fail_addr,      // Address that failed
  output logic [DATA_W-1:0] o_maker_code,     // Maker code read
  output logic [DATA_W-1:0] o_part_code,      // Part code read
  output logic [ADDR_W-1:0] o_mem_addr,       // Memory address pins
  output logic o_mem_sel_n,                   // Chip-select strobe, low active
  output logic o_mem_gate_n,                  // Output-gate strobe, low active
  output logic [DATA_W-1:0] o_data_pins,      // Data pins, driven value
  output logic o_data_pins_oe_n,              // Data pins enable, low drives
  input wire logic [DATA_W-1:0] i_data_pins,  // Data pins, sampled value
  output logic o_core_raise,                  // Main supply at program level
  output logic o_vpp_raise,                   // Programming supply raised
  output logic o_identifier_high_voltage      // Identifier line at elevated level
);

  // Sequencer states
  typedef enum logic [10:0] {
    ST_IDLE  = 11'h001,
    ST_VCC   = 11'h002,
    ST_VPP   = 11'h004,
    ST_SETUP = 11'h008,
    ST_PULSE = 11'h010,
    ST_HOLD  = 11'h020,
    ST_VERIF = 11'h040,
    ST_NEXT  = 11'h080,
    ST_DOWN  = 11'h100,
    ST_CMP   = 11'h200,
    ST_ID    = 11'h400
  } state_t;

  // Two-flop synchroniser on the data pins
  logic [DATA_W-1:0] din_meta_ff;             // First stage
  logic [DATA_W-1:0] din_ff;                  // Second stage, used by logic

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      din_meta_ff <= 8'h00;
      din_ff <= 8'h00;
    end else begin
      din_meta_ff <= i_data_pins;
      din_ff <= din_meta_ff;
    end
  end

  // Registers and next values
  state_t st_ff, nxt_st;                      // Sequencer state
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;          // Phase timer
  logic [TRY_W-1:0] try_ff, nxt_try;          // Pulses on current byte
  logic [1:0] sub_ff, nxt_sub;                // Step within a phase
  logic [ADDR_W-1:0] addr_ff, nxt_addr;       // Current address
  logic [ADDR_W-1:0] last_ff, nxt_last;       // Last address of run
  logic [DATA_W-1:0] dout_ff, nxt_dout;       // Byte on data pins
  logic oe_n_ff, nxt_oe_n;                    // Data pin enable
  logic sel_n_ff, nxt_sel_n;                  // Select strobe
  logic gate_n_ff, nxt_gate_n;                // Gate strobe
  logic core_ff, nxt_core;                    // Main supply raised
  logic vpp_ff, nxt_vpp;                      // Programming supply raised
  logic idhv_ff, nxt_idhv;                    // Identifier elevated
  logic req_ff, nxt_req;                      // Image request
  logic done_ff, nxt_done;                    // Done pulse
  logic fail_ff, nxt_fail;                    // Failure flag
  logic [ADDR_W-1:0] faddr_ff, nxt_faddr;     // Failing address
  logic [DATA_W-1:0] maker_ff, nxt_maker;     // Maker code
  logic [DATA_W-1:0] part_ff, nxt_part;       // Part code
  logic busy_ff, nxt_busy;                    // Run or id read in progress

  // Timer reached its end for a length
  function automatic logic timer_hit(input logic [CNT_W-1:0] c, input int n);
    return c >= CNT_W'(n - 1);
  endfunction : timer_hit

  // Next-state logic for the whole sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 16'h0001;
    nxt_try = try_ff;
    nxt_sub = sub_ff;
    nxt_addr = addr_ff;
    nxt_last = last_ff;
    nxt_dout = dout_ff;
    nxt_oe_n = oe_n_ff;
    nxt_sel_n = sel_n_ff;
    nxt_gate_n = gate_n_ff;
    nxt_core = core_ff;
    nxt_vpp = vpp_ff;
    nxt_idhv = idhv_ff;
    nxt_req = req_ff;
    nxt_done = 1'b0;
    nxt_fail = fail_ff;
    nxt_faddr = faddr_ff;
    nxt_maker = maker_ff;
    nxt_part = part_ff;
    case (st_ff)
      ST_IDLE: begin
        nxt_cnt = 16'h0000;
        nxt_sel_n = 1'b1;                     // Standby while idle
        nxt_gate_n = 1'b1;
        nxt_oe_n = 1'b1;
        if (i_start) begin
          nxt_addr = '0;
          nxt_last = i_last_addr;
          nxt_fail = 1'b0;
          nxt_try = '0;
          nxt_core = 1'b1;                    // Main supply first
          nxt_st = ST_VCC;
        end else if (i_read_id) begin
          nxt_addr = '0;                      // Other address lines low
          nxt_idhv = 1'b1;                    // Identifier as a flag
          nxt_sub = 2'd0;
          nxt_st = ST_ID;
        end
      end
      ST_VCC: begin
        if (timer_hit(cnt_ff, SETUP_CYC)) begin
          nxt_vpp = 1'b1;                     // Raised supply for program
          nxt_cnt = 16'h0000;
          nxt_st = ST_VPP;
        end
      end
      ST_VPP: begin
        if (timer_hit(cnt_ff, SETUP_CYC)) begin
          nxt_req = 1'b1;
          nxt_cnt = 16'h0000;
          nxt_st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Byte on data pins, strobes high: inhibit until set up
        nxt_dout = i_img_data;                // Present byte
        nxt_oe_n = 1'b0;
        nxt_gate_n = 1'b1;
        if (timer_hit(cnt_ff, SETUP_CYC)) begin
          nxt_sel_n = 1'b0;                   // Start pulse, gate high
          nxt_try = try_ff + 5'd1;
          nxt_cnt = 16'h0000;
          nxt_st = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (timer_hit(cnt_ff, PULSE_CYCLES)) begin
          nxt_sel_n = 1'b1;                   // Pulse of nominal length
          nxt_cnt = 16'h0000;
          nxt_st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (timer_hit(cnt_ff, SETUP_CYC)) begin
          nxt_oe_n = 1'b1;                    // Release pins after data hold
          nxt_cnt = 16'h0000;
          nxt_sub = 2'd0;
          nxt_st = ST_VERIF;
        end
      end
      ST_VERIF: begin
        // Verify after each pulse, select high, gate low
        if (sub_ff == 2'd0) begin
          if (timer_hit(cnt_ff, SETUP_CYC)) begin
            nxt_gate_n = 1'b0;
            nxt_cnt = 16'h0000;
            nxt_sub = 2'd1;
          end
        end else if (sub_ff == 2'd1) begin
          if (timer_hit(cnt_ff, OE_VALID_CYC)) begin
            nxt_gate_n = 1'b1;
            nxt_cnt = 16'h0000;
            nxt_sub = 2'd2;
            if (din_ff == dout_ff) begin     // Byte matches
              nxt_st = ST_NEXT;
            end else if (try_ff >= TRY_W'(MAX_TRIES)) begin
              nxt_fail = 1'b1;                // Abandon run
              nxt_faddr = addr_ff;
              nxt_req = 1'b0;
              nxt_st = ST_DOWN;
            end
          end
        end else if (timer_hit(cnt_ff, FLOAT_CYC)) begin
          nxt_cnt = 16'h0000;                 // Pins floated, pulse again
          nxt_st = ST_SETUP;
        end
      end
      ST_NEXT: begin
        nxt_try = '0;
        nxt_cnt = 16'h0000;
        if (addr_ff == last_ff) begin
          nxt_req = 1'b0;
          nxt_st = ST_DOWN;
        end else begin
          nxt_addr = addr_ff + 15'h0001;
          nxt_st = ST_SETUP;
        end
      end
      ST_DOWN: begin
        // Programming supply down first, then main
        if (timer_hit(cnt_ff, SETUP_CYC)) begin
          nxt_cnt = 16'h0000;
          if (vpp_ff) begin
            nxt_vpp = 1'b0;
          end else if (core_ff) begin
            nxt_core = 1'b0;
          end else if (fail_ff) begin
            nxt_done = 1'b1;
            nxt_st = ST_IDLE;
          end else begin
            nxt_addr = '0;
            nxt_sub = 2'd0;
            nxt_req = 1'b1;
            nxt_st = ST_CMP;
          end
        end
      end
      ST_CMP: begin
        // Normal read of every byte against image
        nxt_sel_n = 1'b0;
        nxt_gate_n = 1'b0;
        if (timer_hit(cnt_ff, OE_VALID_CYC)) begin
          nxt_cnt = 16'h0000;
          if (din_ff != i_img_data) begin
            nxt_fail = 1'b1;
            nxt_faddr = addr_ff;
          end
          if (addr_ff == last_ff) begin
            nxt_sel_n = 1'b1;
            nxt_gate_n = 1'b1;
            nxt_req = 1'b0;
            nxt_done = 1'b1;
            nxt_st = ST_IDLE;
          end else begin
            nxt_addr = addr_ff + 15'h0001;
          end
        end
      end
      ST_ID: begin
        // Both strobes low, lowest address picks code
        nxt_sel_n = 1'b0;
        nxt_gate_n = 1'b0;
        if (timer_hit(cnt_ff, SETUP_CYC)) begin
          nxt_cnt = 16'h0000;
          if (sub_ff == 2'd0) begin
            nxt_maker = din_ff;
            nxt_addr = 15'h0001;
            nxt_sub = 2'd1;
          end else begin
            nxt_part = din_ff;
            nxt_addr = '0;
            nxt_idhv = 1'b0;
            nxt_sel_n = 1'b1;
            nxt_gate_n = 1'b1;
            nxt_done = 1'b1;
            nxt_st = ST_IDLE;
          end
        end
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
    nxt_busy = (nxt_st != ST_IDLE);           // Busy flag from a flop, not state decode
  end

  // Register every sequencer value
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_ff <= ST_IDLE;
      cnt_ff <= 16'h0000;
      try_ff <= 5'h00;
      sub_ff <= 2'h0;
      addr_ff <= 15'h0000;
      last_ff <= 15'h0000;
      dout_ff <= 8'hff;                      // Erased value
      oe_n_ff <= 1'b1;
      sel_n_ff <= 1'b1;
      gate_n_ff <= 1'b1;
      core_ff <= 1'b0;
      vpp_ff <= 1'b0;
      idhv_ff <= 1'b0;
      req_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      faddr_ff <= 15'h0000;
      maker_ff <= 8'h00;
      part_ff <= 8'h00;
      busy_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      try_ff <= nxt_try;
      sub_ff <= nxt_sub;
      addr_ff <= nxt_addr;
      last_ff <= nxt_last;
      dout_ff <= nxt_dout;
      oe_n_ff <= nxt_oe_n;
      sel_n_ff <= nxt_sel_n;
      gate_n_ff <= nxt_gate_n;
      core_ff <= nxt_core;
      vpp_ff <= nxt_vpp;
      idhv_ff <= nxt_idhv;
      req_ff <= nxt_req;
      done_ff <= nxt_done;
      fail_ff <= nxt_fail;
      faddr_ff <= nxt_faddr;
      maker_ff <= nxt_maker;
      part_ff <= nxt_part;
      busy_ff <= nxt_busy;
    end
  end

  // Outputs straight from flip-flops
  assign o_img_req = req_ff;
  assign o_img_addr = addr_ff;
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_fail = fail_ff;
  assign o_fail_addr = faddr_ff;
  assign o_maker_code = maker_ff;
  assign o_part_code = part_ff;
  assign o_mem_addr = addr_ff;
  assign o_mem_sel_n = sel_n_ff;
  assign o_mem_gate_n = gate_n_ff;
  assign o_data_pins = dout_ff;
  assign o_data_pins_oe_n = oe_n_ff;
  assign o_core_raise = core_ff;
  assign o_vpp_raise = vpp_ff;
  assign o_identifier_high_voltage = idhv_ff;

endmodule : eprom_programmer
`default_nettype wire

/* File: testbench/eprom_device_model.sv */
// Behavioural model of the UV-erasable memory facing the programmer
// One select per device, gate shared with the read strobe
`timescale 1ns/1ps
`default_nettype none
module eprom_device_model
  import eprom_prog_pkg::*;
#(
  parameter logic [DATA_W-1:0] MAKER_CODE = 8'h21, // Arbitrary maker code
  parameter logic [DATA_W-1:0] PART_CODE = 8'h47   // Arbitrary part code
) (
  input wire logic [ADDR_W-1:0] i_addr,    // Address pins
  input wire logic i_sel_n,                // Chip-select strobe
  input wire logic i_gate_n,               // Output-gate strobe
  input wire logic i_vpp,                  // Programming supply raised
  input wire logic i_core,                 // Main supply at program level
  input wire logic i_id_hv,                // Identifier line elevated
  input wire logic [DATA_W-1:0] i_ctl_data, // Byte the programmer drives
  input wire logic i_ctl_oe_n,             // Programmer drives when low
  output logic [DATA_W-1:0] o_dq           // Resolved data pin level
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Array contents
  logic [DATA_W-1:0] dev_val; // Byte the memory would drive
  logic [DATA_W-1:0] last_val; // Last driven level
  logic dev_drv; // Memory drives the pins
  logic id_hit; // Identifier condition met
  // Erased array reads all ones
  initial begin
    for (int a = 0; a < (1 << ADDR_W); a++) mem[a] = 8'hff;
  end
  // Read, identifier read and verify drive; standby and inhibit float
  assign dev_drv = !i_gate_n && (!i_sel_n || i_vpp);
  assign id_hit = i_id_hv && !i_sel_n && (i_addr[ADDR_W-1:1] == '0);
  assign dev_val = id_hit ? (i_addr[0] ? PART_CODE : MAKER_CODE) : mem[i_addr];
  // End of a program pulse clears bits only
  always @(posedge i_sel_n) begin
    if (i_vpp && i_core && i_gate_n && !i_ctl_oe_n) begin
      mem[i_addr] = mem[i_addr] & i_ctl_data;
    end
  end
  // Released pins show the inverse of the last level
  always @* begin
    if (!i_ctl_oe_n) o_dq = i_ctl_data;
    else if (dev_drv) o_dq = dev_val;
    else o_dq = ~last_val;
  end
  // Remember what was driven
  always @* begin
    if (!i_ctl_oe_n || dev_drv) last_val = o_dq;
  end
endmodule : eprom_device_model
`default_nettype wire

/* File: testbench/eprom_programmer_props.sv */
// Pin-level assertions for the memory programmer controller
`timescale 1ns/1ps
`default_nettype none
module eprom_programmer_props
  import eprom_prog_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC // Program pulse length
) (
  input wire logic i_clk,                    // Clock
  input wire logic i_resetn,                 // Reset, active low
  input wire logic o_done,                   // Run finished
  input wire logic [ADDR_W-1:0] o_mem_addr,  // Address pins
  input wire logic o_mem_sel_n,              // Chip-select strobe
  input wire logic o_mem_gate_n,             // Output-gate strobe
  input wire logic [DATA_W-1:0] o_data_pins, // Driven byte
  input wire logic o_data_pins_oe_n,         // Drive enable, low drives
  input wire logic o_core_raise,             // Main supply raised
  input wire logic o_vpp_raise,              // Programming supply raised
  input wire logic o_identifier_high_voltage // Identifier line elevated
);
  logic [CNT_W-1:0] low_cnt_ff, nxt_low_cnt; // Cycles with select low
  logic [TRY_W:0] try_ff, nxt_try; // Pulses on this address
  logic [ADDR_W-1:0] addr_ff; // Previous address
  logic sel_ff; // Previous select level
  // Next values of the helper counters
  always_comb begin
    nxt_low_cnt = o_mem_sel_n ? '0 : low_cnt_ff + 1'b1;
    nxt_try = (o_mem_addr != addr_ff || !o_vpp_raise) ? '0 : try_ff;
    if (o_vpp_raise && sel_ff && !o_mem_sel_n) nxt_try = nxt_try + 1'b1;
  end
  // Helper registers
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cnt_ff <= '0;
      try_ff <= '0;
      addr_ff <= '0;
      sel_ff <= 1'b1;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
      try_ff <= nxt_try;
      addr_ff <= o_mem_addr;
      sel_ff <= o_mem_sel_n;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence prog_start_s;
    $fell(o_mem_sel_n) && !o_data_pins_oe_n;
  endsequence
  sequence pulse_end_s;
    $rose(o_mem_sel_n) && o_vpp_raise;
  endsequence
  sequence verify_s;
    o_mem_sel_n throughout (##[1:300] $fell(o_mem_gate_n));
  endsequence
  chk_pulse_width: assert property (pulse_end_s |-> low_cnt_ff == PULSE_CYCLES)
    else $error("program pulse length wrong");
  chk_pulse_setup: assert property (prog_start_s |-> o_mem_gate_n && o_vpp_raise && o_core_raise)
    else $error("program pulse without program conditions");
  chk_pulse_hold: assert property (!o_mem_sel_n && o_vpp_raise |=>
    $stable(o_mem_addr) && $stable(o_data_pins) && !o_data_pins_oe_n)
    else $error("address or byte moved during pulse");
  chk_verify_next: assert property (pulse_end_s |-> verify_s)
    else $error("no verify after program pulse");
  chk_no_clash: assert property (!o_data_pins_oe_n |-> o_mem_gate_n)
    else $error("controller drives while memory may drive");
  chk_float_wait: assert property ($fell(o_mem_gate_n) |-> $past(o_data_pins_oe_n, 6))
    else $error("gate opened too soon after release");
  chk_supply_order: assert property (o_vpp_raise |-> o_core_raise)
    else $error("programming supply up without main supply");
  chk_vpp_lead: assert property ($rose(o_vpp_raise) |-> $past(o_core_raise, 80))
    else $error("main supply not raised early enough");
  chk_try_limit: assert property (try_ff <= MAX_TRIES)
    else $error("too many pulses on one byte");
  chk_done_normal: assert property (o_done |-> !o_vpp_raise && !o_core_raise)
    else $error("run ended with raised supplies");
  chk_id_address: assert property (o_identifier_high_voltage && !o_mem_gate_n |->
    !o_vpp_raise && o_mem_addr[ADDR_W-1:1] == '0)
    else $error("identifier read with wrong address");
endmodule : eprom_programmer_props
bind eprom_programmer eprom_programmer_props #(.PULSE_CYCLES(PULSE_CYCLES)) u_props (.*);
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for the memory programmer controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import eprom_prog_pkg::*;
  localparam int PULSE_CYCLES = 40; // Shortened program pulse
  localparam logic [7:0] MAKER_ID = 8'h21; // Arbitrary maker code
  localparam logic [7:0] PART_ID = 8'h47; // Arbitrary part code
  logic i_clk, i_resetn, i_start, i_read_id; // Clock, reset, commands
  logic [ADDR_W-1:0] i_last_addr, o_img_addr, o_fail_addr, o_mem_addr; // Addresses
  logic [DATA_W-1:0] i_img_data, o_maker_code, o_part_code, o_data_pins, i_data_pins; // Bytes
  logic o_img_req, o_busy, o_done, o_fail, o_mem_sel_n, o_mem_gate_n, o_data_pins_oe_n; // Flags
  logic o_core_raise, o_vpp_raise, o_identifier_high_voltage; // Supply controls
  logic [DATA_W-1:0] img [0:3]; // Image bytes
  int err_count, compares, pulses; // Tallies
  eprom_programmer #(.PULSE_CYCLES(PULSE_CYCLES)) u_eprom_programmer (.*);
  eprom_device_model #(.MAKER_CODE(MAKER_ID), .PART_CODE(PART_ID)) u_eprom_device_model (
    .i_addr(o_mem_addr), .i_sel_n(o_mem_sel_n), .i_gate_n(o_mem_gate_n),
    .i_vpp(o_vpp_raise), .i_core(o_core_raise), .i_id_hv(o_identifier_high_voltage),
    .i_ctl_data(o_data_pins), .i_ctl_oe_n(o_data_pins_oe_n), .o_dq(i_data_pins));
  assign i_img_data = img[o_img_addr[1:0]]; // Image follows wanted address
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // Count program pulses
  always @(negedge o_mem_sel_n) begin
    if (o_vpp_raise) pulses++;
  end
  task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Issue one command and wait for its end
  task automatic run_cmd(input logic is_id, input logic [ADDR_W-1:0] last);
    int n;
    @(posedge i_clk);
    #2 i_start = !is_id;
    i_read_id = is_id;
    i_last_addr = last;
    @(posedge i_clk);
    #2 i_start = 1'b0;
    i_read_id = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 20000) begin
      @(posedge i_clk);
      #2 n++;
    end
    if (n >= 20000) begin
      err_count++;
      give_verdict();
    end
  endtask : run_cmd
  task automatic t_reset();
    check_val("idle pins", 16'h0070, 16'({o_mem_sel_n, o_mem_gate_n, o_data_pins_oe_n,
      o_core_raise, o_vpp_raise, o_identifier_high_voltage, o_busy}));
  endtask : t_reset
  task automatic t_prog_ok();
    run_cmd(1'b0, 15'd3);
    check_val("run fail flag", 16'h0, 16'(o_fail));
    for (int a = 0; a < 4; a++) begin
      check_val("stored byte", 16'(img[a]), 16'(u_eprom_device_model.mem[a]));
    end
  endtask : t_prog_ok
  task automatic t_id();
    run_cmd(1'b1, 15'd0);
    check_val("maker code", 16'(MAKER_ID), 16'(o_maker_code));
    check_val("part code", 16'(PART_ID), 16'(o_part_code));
  endtask : t_id
  task automatic t_prog_abort();
    img[0] = 8'hff;
    pulses = 0;
    run_cmd(1'b0, 15'd3);
    check_val("abort fail flag", 16'h1, 16'(o_fail));
    check_val("abort address", 16'h0, 16'(o_fail_addr));
    check_val("abort pulses", 16'd25, 16'(pulses));
    check_val("kept byte", 16'h5a, 16'(u_eprom_device_model.mem[0]));
  endtask : t_prog_abort
  task automatic t_reprog();
    img[0] = 8'h10;
    run_cmd(1'b0, 15'd0);
    check_val("rerun fail flag", 16'h0, 16'(o_fail));
    check_val("cleared byte", 16'h10, 16'(u_eprom_device_model.mem[0]));
    check_val("supplies low", 16'h0, 16'({o_core_raise, o_vpp_raise}));
  endtask : t_reprog
  // Main sequence
  initial begin
    i_resetn = 1'b0;
    i_start = 1'b0;
    i_read_id = 1'b0;
    i_last_addr = '0;
    err_count = 0;
    compares = 0;
    pulses = 0;
    img = '{8'h5a, 8'hff, 8'h00, 8'ha5};
    repeat (16) @(posedge i_clk);
    #2 i_resetn = 1'b1;
    t_reset();
    t_prog_ok();
    t_id();
    t_prog_abort();
    t_reprog();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
